// ==== lsdc_pkg.sv ====
// Shared constants and types for the load shed and display controller.
package lsdc_pkg;
   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [7:0] LSDC_CTRL_OFS = 8'h00;
   localparam logic [7:0] LSDC_STATUS_OFS = 8'h04;
   localparam logic [7:0] LSDC_METER_OFS = 8'h08;
   localparam logic [7:0] LSDC_LEARN_OFS = 8'h10;
   localparam logic [7:0] LSDC_LEARN_END = 8'h24;
   localparam logic [31:0] LSDC_CTRL_RST = 32'h0000_0001;
   localparam int LSDC_CTRL_EM_BIT = 0;
   localparam logic [1:0] LSDC_OKAY = 2'h0;
   localparam logic [1:0] LSDC_SLVERR = 2'h2;
   // ----------------------------------------
   // Service ratings and loads
   // ----------------------------------------
   localparam logic [7:0] LSDC_GAS_AMPS = 8'h2d;
   localparam logic [7:0] LSDC_DIESEL_AMPS = 8'h3c;
   localparam logic [7:0] LSDC_SHORE30_AMPS = 8'h1e;
   localparam logic [7:0] LSDC_SHORE20_AMPS = 8'h14;
   localparam int LSDC_NUM_LOADS = 6;
   localparam logic [2:0] LSDC_LAST_IDX = 3'h5;
   localparam int LSDC_LED_GEN = 0;
   localparam int LSDC_LED_240 = 1;
   localparam int LSDC_LED_30 = 2;
   localparam int LSDC_LED_20 = 3;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam longint LSDC_CLK_HZ = 100_000_000;
   localparam longint LSDC_MIN_OFF_S = 120;
   localparam longint LSDC_DEBOUNCE_MS = 20;
   localparam longint LSDC_HOLD_MS = 1000;
   localparam longint LSDC_SETTLE_MS = 500;
   localparam longint LSDC_MIN_OFF_CYC = LSDC_MIN_OFF_S * LSDC_CLK_HZ;
   localparam longint LSDC_DEBOUNCE_CYC = (LSDC_DEBOUNCE_MS * LSDC_CLK_HZ) / 1000;
   localparam longint LSDC_HOLD_CYC = (LSDC_HOLD_MS * LSDC_CLK_HZ) / 1000;
   localparam longint LSDC_SETTLE_CYC = (LSDC_SETTLE_MS * LSDC_CLK_HZ) / 1000;
   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [3:0] {
      LSDC_SRC_NONE = 4'b0001,
      LSDC_SRC_GEN = 4'b0010,
      LSDC_SRC_240 = 4'b0100,
      LSDC_SRC_120 = 4'b1000
   } lsdc_src_t;
   typedef enum logic [1:0] {
      LSDC_SH_RUN = 2'b01,
      LSDC_SH_SETTLE = 2'b10
   } lsdc_shed_t;
endpackage : lsdc_pkg

// ==== lsdc_top.sv ====
// Load shedding, service mode and display control with an AXI4-Lite slave.
//
// Design decisions made here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/10ps
module lsdc_top
   import lsdc_pkg::*;
#(
   parameter longint MIN_OFF_CYC = LSDC_MIN_OFF_CYC,
   parameter longint DEBOUNCE_CYC = LSDC_DEBOUNCE_CYC,
   parameter longint HOLD_CYC = LSDC_HOLD_CYC,
   parameter longint SETTLE_CYC = LSDC_SETTLE_CYC
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // AXI4-Lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Source sensing and current
   input wire logic line_present,
   input wire logic line240_present,
   input wire logic gen_run,
   input wire logic [7:0] total_amps,
   // Jumpers, high when installed
   input wire logic generator_rating_jumper,
   input wire logic shed_order_select_first,
   input wire logic shed_order_select_second,
   input wire logic shed_order_select_third,
   // Panel
   input wire logic service_button,
   output logic [3:0] service_led,
   output logic [5:0] load_led,
   output logic [7:0] meter_amps,
   output logic meter_blank,
   // Relays
   output logic [3:0] line_relay,
   output logic [1:0] lowv_relay
);
   // ----------------------------------------
   // Functions
   // ----------------------------------------
   // Relay index (0..5) shed at position k of column col.
   function automatic logic [2:0] shed_relay(input logic [2:0] col, input logic [2:0] k);
      logic [17:0] t;
      t = 18'h0;
      case (col)
         3'h0: t = {3'd1, 3'd2, 3'd3, 3'd4, 3'd5, 3'd6};
         3'h1: t = {3'd1, 3'd2, 3'd3, 3'd5, 3'd6, 3'd4};
         3'h2: t = {3'd1, 3'd2, 3'd5, 3'd6, 3'd3, 3'd4};
         3'h3: t = {3'd1, 3'd5, 3'd6, 3'd2, 3'd3, 3'd4};
         3'h4: t = {3'd5, 3'd6, 3'd1, 3'd2, 3'd3, 3'd4};
         3'h5: t = {3'd1, 3'd2, 3'd3, 3'd5, 3'd4, 3'd6};
         3'h6: t = {3'd1, 3'd2, 3'd5, 3'd3, 3'd6, 3'd4};
         default: t = {3'd1, 3'd5, 3'd2, 3'd6, 3'd3, 3'd4};
      endcase
      shed_relay = 3'(t[3 * k +: 3] - 3'd1);
   endfunction : shed_relay
   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   logic [11:0] pin_s1_reg, pin_s2_reg;
   logic [7:0] amps_s1_reg, amps_reg;
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         pin_s1_reg <= 12'h000;
         pin_s2_reg <= 12'h000;
         amps_s1_reg <= 8'h00;
         amps_reg <= 8'h00;
      end else begin
         pin_s1_reg <= {4'h0, line_present, line240_present, gen_run, generator_rating_jumper,
                        shed_order_select_first, shed_order_select_second,
                        shed_order_select_third, service_button};
         pin_s2_reg <= pin_s1_reg;
         amps_s1_reg <= total_amps;
         amps_reg <= amps_s1_reg;
      end
   end
   logic btn_raw, gen_jp;
   logic [2:0] col;
   assign btn_raw = pin_s2_reg[0];
   assign col = ~pin_s2_reg[3:1];
   assign gen_jp = pin_s2_reg[4];
   // ----------------------------------------
   // Source detection and limit
   // ----------------------------------------
   lsdc_src_t src;
   logic [7:0] limit;
   logic thr20_reg, em_en_reg, tgl;
   lsdc_src_t src_reg;
   always_comb begin
      if (pin_s2_reg[5]) begin
         src = LSDC_SRC_GEN;
      end else if (pin_s2_reg[6]) begin
         src = LSDC_SRC_240;
      end else if (pin_s2_reg[7]) begin
         src = LSDC_SRC_120;
      end else begin
         src = LSDC_SRC_NONE;
      end
   end
   always_comb begin
      if (src == LSDC_SRC_GEN) begin
         limit = gen_jp ? LSDC_GAS_AMPS : LSDC_DIESEL_AMPS;
      end else begin
         limit = thr20_reg ? LSDC_SHORE20_AMPS : LSDC_SHORE30_AMPS;
      end
   end
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         src_reg <= LSDC_SRC_NONE;
         thr20_reg <= 1'b0;
      end else begin
         src_reg <= src;
         if (src == LSDC_SRC_120 && src_reg != LSDC_SRC_120) begin
            thr20_reg <= 1'b0;
         end else if (tgl) begin
            thr20_reg <= ~thr20_reg;
         end
      end
   end
   // ----------------------------------------
   // Button debounce, press and hold
   // ----------------------------------------
   logic btn_db_reg, hold_ok_reg, held_reg;
   logic [39:0] db_cnt_reg, hold_cnt_reg;
   logic press, release_ev, hold_fire;
   logic disp_reg;
   logic [2:0] idx_reg;
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         btn_db_reg <= 1'b0;
         db_cnt_reg <= 40'h0;
      end else if (btn_raw == btn_db_reg) begin
         db_cnt_reg <= 40'h0;
      end else if (db_cnt_reg >= 40'(DEBOUNCE_CYC - 1)) begin
         btn_db_reg <= btn_raw;
         db_cnt_reg <= 40'h0;
      end else begin
         db_cnt_reg <= db_cnt_reg + 40'h1;
      end
   end
   assign press = btn_raw && !btn_db_reg && db_cnt_reg >= 40'(DEBOUNCE_CYC - 1);
   assign release_ev = !btn_raw && btn_db_reg && db_cnt_reg >= 40'(DEBOUNCE_CYC - 1);
   assign hold_fire = btn_db_reg && hold_ok_reg && !held_reg
                      && hold_cnt_reg >= 40'(HOLD_CYC - 1);
   assign tgl = release_ev && hold_ok_reg && !held_reg && src == LSDC_SRC_120;
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         hold_ok_reg <= 1'b0;
         held_reg <= 1'b0;
         hold_cnt_reg <= 40'h0;
      end else if (press) begin
         hold_ok_reg <= !disp_reg;
         held_reg <= 1'b0;
         hold_cnt_reg <= 40'h0;
      end else if (btn_db_reg) begin
         hold_cnt_reg <= hold_cnt_reg + 40'h1;
         if (hold_fire) begin
            held_reg <= 1'b1;
         end
      end else begin
         hold_ok_reg <= 1'b0;
      end
   end
   // ----------------------------------------
   // Stored value display
   // ----------------------------------------
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         disp_reg <= 1'b0;
         idx_reg <= 3'h0;
      end else if (hold_fire) begin
         disp_reg <= 1'b1;
         idx_reg <= 3'h0;
      end else if (press && disp_reg) begin
         if (idx_reg == LSDC_LAST_IDX) begin
            disp_reg <= 1'b0;
         end else begin
            idx_reg <= idx_reg + 3'h1;
         end
      end
   end
   // ----------------------------------------
   // Shedding and restoring
   // ----------------------------------------
   // The column is read live; moving a jumper while loads are shed is not supported.
   lsdc_shed_t sh_reg;
   logic [5:0] relay_on_reg;
   logic [2:0] depth_reg, victim_reg;
   logic [7:0] pre_reg;
   logic [7:0] learned_reg [LSDC_NUM_LOADS];
   logic [39:0] settle_reg, off_reg;
   logic em_act, shed_go, restore_go;
   logic [2:0] top_relay, next_relay;
   assign em_act = em_en_reg && (src == LSDC_SRC_GEN || src == LSDC_SRC_120);
   assign next_relay = shed_relay(col, depth_reg);
   assign top_relay = shed_relay(col, 3'(depth_reg - 3'h1));
   assign shed_go = em_act && sh_reg == LSDC_SH_RUN && amps_reg > limit
                    && depth_reg < 3'(LSDC_NUM_LOADS);
   assign restore_go = em_act && sh_reg == LSDC_SH_RUN && !shed_go && depth_reg != 3'h0
                       && off_reg == 40'h0 && amps_reg < limit
                       && 8'(limit - amps_reg) >= learned_reg[top_relay];
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         sh_reg <= LSDC_SH_RUN;
         relay_on_reg <= 6'h00;
         depth_reg <= 3'h0;
         victim_reg <= 3'h0;
         pre_reg <= 8'h00;
         settle_reg <= 40'h0;
         off_reg <= 40'h0;
         for (int i = 0; i < LSDC_NUM_LOADS; i++) begin
            learned_reg[i] <= 8'h00;
         end
      end else if (!em_act) begin
         // 240 V service or management disabled: every load on; no power: all off.
         sh_reg <= LSDC_SH_RUN;
         relay_on_reg <= (src == LSDC_SRC_NONE) ? 6'h00 : 6'h3f;
         depth_reg <= 3'h0;
         off_reg <= 40'h0;
      end else begin
         if (off_reg != 40'h0) begin
            off_reg <= off_reg - 40'h1;
         end
         case (sh_reg)
            LSDC_SH_RUN: begin
               if (shed_go) begin
                  relay_on_reg[next_relay] <= 1'b0;
                  victim_reg <= next_relay;
                  pre_reg <= amps_reg;
                  depth_reg <= depth_reg + 3'h1;
                  settle_reg <= 40'h0;
                  sh_reg <= LSDC_SH_SETTLE;
               end else if (restore_go) begin
                  relay_on_reg[top_relay] <= 1'b1;
                  depth_reg <= depth_reg - 3'h1;
               end else if (depth_reg == 3'h0) begin
                  relay_on_reg <= 6'h3f;
               end
            end
            LSDC_SH_SETTLE: begin
               // The drop is measured only after the sensor has settled.
               if (settle_reg >= 40'(SETTLE_CYC - 1)) begin
                  learned_reg[victim_reg] <= (pre_reg > amps_reg) ? 8'(pre_reg - amps_reg)
                                                                  : 8'h00;
                  off_reg <= 40'(MIN_OFF_CYC);
                  sh_reg <= LSDC_SH_RUN;
               end else begin
                  settle_reg <= settle_reg + 40'h1;
               end
            end
            default: sh_reg <= LSDC_SH_RUN;
         endcase
      end
   end
   assign line_relay = relay_on_reg[3:0];
   assign lowv_relay = relay_on_reg[5:4];
   // ----------------------------------------
   // Indicators and meter
   // ----------------------------------------
   logic [3:0] svc_reg;
   logic [5:0] led_reg;
   logic [7:0] meter_reg;
   logic blank_reg;
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         svc_reg <= 4'h0;
         led_reg <= 6'h00;
         meter_reg <= 8'h00;
         blank_reg <= 1'b1;
      end else begin
         svc_reg[LSDC_LED_GEN] <= src == LSDC_SRC_GEN;
         svc_reg[LSDC_LED_240] <= src == LSDC_SRC_240;
         svc_reg[LSDC_LED_30] <= src == LSDC_SRC_120 && !thr20_reg;
         svc_reg[LSDC_LED_20] <= src == LSDC_SRC_120 && thr20_reg;
         led_reg <= disp_reg ? 6'(6'h01 << idx_reg) : relay_on_reg;
         meter_reg <= disp_reg ? learned_reg[idx_reg] : amps_reg;
         blank_reg <= !disp_reg && (src == LSDC_SRC_240 || src == LSDC_SRC_NONE);
      end
   end
   assign service_led = svc_reg;
   assign load_led = led_reg;
   assign meter_amps = meter_reg;
   assign meter_blank = blank_reg;
   // ----------------------------------------
   // AXI4-Lite slave
   // ----------------------------------------
   logic aw_got_reg, w_got_reg, bvalid_reg, rvalid_reg;
   logic [7:0] awaddr_reg;
   logic [31:0] wdata_reg, rdata_reg;
   logic [3:0] wstrb_reg;
   logic [1:0] bresp_reg, rresp_reg;
   assign s_axi_awready = !aw_got_reg && !bvalid_reg;
   assign s_axi_wready = !w_got_reg && !bvalid_reg;
   assign s_axi_arready = !rvalid_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         aw_got_reg <= 1'b0;
         w_got_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_reg <= LSDC_OKAY;
         awaddr_reg <= 8'h00;
         wdata_reg <= 32'h0;
         wstrb_reg <= 4'h0;
         em_en_reg <= LSDC_CTRL_RST[LSDC_CTRL_EM_BIT];
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got_reg <= 1'b1;
            awaddr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got_reg <= 1'b1;
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
         end
         if (aw_got_reg && w_got_reg) begin
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            bvalid_reg <= 1'b1;
            if (awaddr_reg[7:2] == LSDC_CTRL_OFS[7:2]) begin
               bresp_reg <= LSDC_OKAY;
               if (wstrb_reg[0]) begin
                  em_en_reg <= wdata_reg[LSDC_CTRL_EM_BIT];
               end
            end else begin
               bresp_reg <= LSDC_SLVERR;
            end
         end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
         end
      end
   end
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0;
         rresp_reg <= LSDC_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_reg <= 1'b1;
         rresp_reg <= LSDC_OKAY;
         if (s_axi_araddr[7:2] == LSDC_CTRL_OFS[7:2]) begin
            rdata_reg <= {31'h0, em_en_reg};
         end else if (s_axi_araddr[7:2] == LSDC_STATUS_OFS[7:2]) begin
            rdata_reg <= {14'h0, depth_reg, col, relay_on_reg, disp_reg, thr20_reg, src};
         end else if (s_axi_araddr[7:2] == LSDC_METER_OFS[7:2]) begin
            rdata_reg <= {16'h0, limit, amps_reg};
         end else if (s_axi_araddr >= LSDC_LEARN_OFS
                      && s_axi_araddr <= LSDC_LEARN_END + 8'h3) begin
            rdata_reg <= {24'h0, learned_reg[3'(s_axi_araddr[4:2] - LSDC_LEARN_OFS[4:2])]};
         end else begin
            rdata_reg <= 32'h0;
            rresp_reg <= LSDC_SLVERR;
         end
      end else if (s_axi_rready) begin
         rvalid_reg <= 1'b0;
      end
   end
   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);
   thr_enter_a: assert property ($rose(src == LSDC_SRC_120) |=> !thr20_reg)
      else $error("threshold not 30 A on shore arrival");
   led_30_a: assert property (
      ##1 svc_reg[LSDC_LED_30] == $past(src == LSDC_SRC_120 && !thr20_reg))
      else $error("30/20 indicator wrong");
   thr_toggle_a: assert property (
      tgl && !$rose(src == LSDC_SRC_120) |=> thr20_reg != $past(thr20_reg))
      else $error("threshold did not toggle");
   src_gen_a: assert property (pin_s2_reg[5] |=> svc_reg == 4'h1)
      else $error("generator indicator wrong");
   load_led_a: assert property (!disp_reg |=> led_reg == $past(relay_on_reg))
      else $error("load indicator differs from relay");
   meter_total_a: assert property (!disp_reg |=> meter_reg == $past(amps_reg))
      else $error("meter not showing total");
   disp_enter_a: assert property (
      hold_fire |=> disp_reg && idx_reg == 3'h0 ##1 led_reg == 6'h01)
      else $error("stored display entry wrong");
   disp_next_a: assert property (
      press && disp_reg && idx_reg < LSDC_LAST_IDX |=> idx_reg == $past(idx_reg) + 3'h1)
      else $error("stored display did not advance");
   disp_exit_a: assert property (
      press && disp_reg && idx_reg == LSDC_LAST_IDX |=> !disp_reg)
      else $error("stored display did not exit");
   gen_limit_a: assert property (
      src == LSDC_SRC_GEN |-> limit == (gen_jp ? 8'h2d : 8'h3c))
      else $error("generator limit wrong");
   shed_off_a: assert property (
      shed_go |=> !relay_on_reg[$past(next_relay)] && sh_reg == LSDC_SH_SETTLE)
      else $error("shed did not switch load off");
   min_off_a: assert property (
      em_act && sh_reg == LSDC_SH_SETTLE && settle_reg >= 40'(SETTLE_CYC - 1)
      |=> off_reg == 40'(MIN_OFF_CYC))
      else $error("minimum off timer not started");
   cover_hold_c: cover property (hold_fire ##[1:1000] press);
   cover_shed_c: cover property (shed_go);
   cover_restore_c: cover property (restore_go);
   cover_exit_c: cover property (press && disp_reg && idx_reg == LSDC_LAST_IDX);
endmodule : lsdc_top

// ==== lsdc_panel.sv ====
// Model of the remote display panel and its operator push button.
`timescale 1ns/10ps
module lsdc_panel (
   // Clock
   input wire logic mclk,
   // Push button, high while pressed
   output logic service_button
);
   initial service_button = 1'b0;
   // The release gap outlasts the synchroniser and debounce, so presses never merge.
   task press(input int n);
      service_button <= 1'b1;
      repeat (n) @(posedge mclk);
      service_button <= 1'b0;
      repeat (25) @(posedge mclk);
   endtask : press
endmodule : lsdc_panel

// ==== lsdc_top_tb.sv ====
// Self-checking testbench for the load shed and display controller.
`timescale 1ns/10ps
module lsdc_top_tb;
   import lsdc_pkg::*;
   logic mclk = 1'b0;
   logic rstn = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, total_amps = 8'h0c;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic line_present = 1'b1, line240_present = 1'b0, gen_run = 1'b0;
   logic generator_rating_jumper = 1'b1, shed_order_select_first = 1'b1;
   logic shed_order_select_second = 1'b1, shed_order_select_third = 1'b1;
   logic service_button, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, meter_blank;
   logic [1:0] s_axi_bresp, s_axi_rresp, lowv_relay;
   logic [31:0] s_axi_rdata, rd_data;
   logic [1:0] rd_resp;
   logic [3:0] service_led, line_relay;
   logic [5:0] load_led;
   logic [7:0] meter_amps;
   int n_mismatch = 0;
   int num_checks = 0;
   int cycles = 0;
   int k;

   always #5 mclk = ~mclk;

   lsdc_top #(.MIN_OFF_CYC(200), .DEBOUNCE_CYC(4), .HOLD_CYC(50), .SETTLE_CYC(10)) DUT (
      .mclk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .line_present, .line240_present,
      .gen_run, .total_amps, .generator_rating_jumper, .shed_order_select_first,
      .shed_order_select_second, .shed_order_select_third, .service_button,
      .service_led, .load_led, .meter_amps, .meter_blank, .line_relay, .lowv_relay);

   lsdc_panel pnl (.mclk(mclk), .service_button(service_button));

   // ----------------------------------------
   // Bus and check tasks
   // ----------------------------------------
   task stop_test();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : stop_test

   always @(posedge mclk) begin
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         stop_test();
      end
   end

   task chk(input logic [31:0] s, input logic [31:0] e);
      num_checks++;
      if (s !== e) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t seen %h expected %h", $time, s, e);
      end
   endtask : chk

   task cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask : cyc

   task rd(input logic [7:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge mclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge mclk); while (!s_axi_rvalid);
      rd_data = s_axi_rdata;
      rd_resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : rd

   // Address and data are released independently, each at the edge that takes it.
   task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      logic aw_done;
      logic w_done;
      aw_done = 1'b0;
      w_done = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!aw_done || !w_done) begin
         @(posedge mclk);
         if (!aw_done && s_axi_awready) begin
            aw_done = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w_done && s_axi_wready) begin
            w_done = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      while (!s_axi_bvalid) @(posedge mclk);
      rd_resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : wr

   // ----------------------------------------
   // Test sequence
   // ----------------------------------------
   initial begin
      repeat (20) @(posedge mclk);
      rstn <= 1'b1;
      cyc(30);
      chk(service_led, 4'b0100);
      chk(meter_amps, 8'h0c);
      chk(load_led, {lowv_relay, line_relay});
      pnl.press(15);
      chk(service_led, 4'b1000);
      pnl.press(15);
      chk(service_led, 4'b0100);
      $display("test service done");
      for (k = 0; k < 8; k++) begin
         {shed_order_select_first, shed_order_select_second, shed_order_select_third} <= ~k[2:0];
         cyc(10);
         rd(8'h04);
         chk(rd_data[14:12], k[2:0]);
      end
      {shed_order_select_first, shed_order_select_second, shed_order_select_third} <= 3'h7;
      gen_run <= 1'b1;
      cyc(10);
      chk(service_led, 4'b0001);
      rd(8'h08);
      chk(rd_data[15:8], LSDC_GAS_AMPS);
      generator_rating_jumper <= 1'b0;
      cyc(10);
      rd(8'h08);
      chk(rd_data[15:8], LSDC_DIESEL_AMPS);
      generator_rating_jumper <= 1'b1;
      cyc(10);
      $display("test jumpers done");
      total_amps <= 8'h32;
      for (k = 0; k < 100 && lowv_relay[1] !== 1'b0; k++) @(posedge mclk);
      total_amps <= 8'h28;
      chk({lowv_relay, line_relay}, 6'h1f);
      cyc(30);
      chk(load_led, 6'h1f);
      rd(8'h24);
      chk(rd_data[7:0], 8'h0a);
      total_amps <= 8'h1e;
      cyc(60);
      chk(lowv_relay, 2'b01);
      cyc(250);
      chk(lowv_relay, 2'b11);
      $display("test shedding done");
      pnl.press(80);
      chk({load_led, meter_amps}, {6'h01, 8'h00});
      for (k = 1; k < 6; k++) begin
         pnl.press(15);
         chk({load_led, meter_amps}, {6'h01 << k, (k == 5) ? 8'h0a : 8'h00});
      end
      pnl.press(15);
      chk({load_led, meter_amps}, {6'h3f, 8'h1e});
      $display("test stored display done");
      gen_run <= 1'b0;
      line240_present <= 1'b1;
      cyc(10);
      chk({service_led, meter_blank, load_led}, {4'b0010, 1'b1, 6'h3f});
      rd(8'h0c);
      chk(rd_resp, LSDC_SLVERR);
      wr(8'h04, 32'h0, 4'hf);
      chk(rd_resp, LSDC_SLVERR);
      rd(8'h00);
      chk(rd_data, LSDC_CTRL_RST);
      $display("test service type and bus done");
      line240_present <= 1'b0;
      total_amps <= 8'h0c;
      cyc(10);
      pnl.press(15);
      chk(service_led, 4'b1000);
      line_present <= 1'b0;
      cyc(10);
      chk({service_led, meter_blank, load_led}, {4'h0, 1'b1, 6'h00});
      line_present <= 1'b1;
      cyc(10);
      chk(service_led, 4'b0100);
      $display("test shore arrival done");
      wr(8'h00, 32'h0, 4'he);
      chk(rd_resp, LSDC_OKAY);
      rd(8'h00);
      chk(rd_data, LSDC_CTRL_RST);
      wr(8'h00, 32'h0, 4'h1);
      chk(rd_resp, LSDC_OKAY);
      total_amps <= 8'h32;
      cyc(20);
      chk({lowv_relay, line_relay}, 6'h3f);
      rstn <= 1'b0;
      cyc(2);
      chk({service_led, load_led, meter_amps, meter_blank, lowv_relay, line_relay},
          {4'h0, 6'h00, 8'h00, 1'b1, 6'h00});
      total_amps <= 8'h0c;
      rstn <= 1'b1;
      cyc(30);
      rd(8'h00);
      chk(rd_data, LSDC_CTRL_RST);
      chk(service_led, 4'b0100);
      $display("test control and reset done");
      stop_test();
   end
endmodule : lsdc_top_tb
